// >>> hw/i2csm_top.sv
// I2C slave status and address-mask unit behind an AHB-Lite slave port.
// Assumes a single AHB master, zero-wait answers, and a free link clock.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "i2csm_map.svh"
module i2csm_top (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o
);
	import i2csm_pkg::*;

	i2csm_core_type q, n;
	i2csm_link_if lk ();
	logic ev_start, ev_stop, ev_addr, ev_rx, ev_txd;
	logic take, rd_take;
	logic [1:0] hsize_unused;

	// Only whole-word transfers are expected; size is not decoded
	assign hsize_unused = hsize_i[1:0];

	i2csm_link u_link (
		.link_clk_i(link_clk_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.lk(lk)
	);

	// Event = toggle edge after two flops; its data word is long settled
	assign ev_start = q.sy_start[2] ^ q.sy_start[1];
	assign ev_stop = q.sy_stop[2] ^ q.sy_stop[1];
	assign ev_addr = q.sy_addr[2] ^ q.sy_addr[1];
	assign ev_rx = q.sy_rx[2] ^ q.sy_rx[1];
	assign ev_txd = q.sy_txd[2] ^ q.sy_txd[1];
	assign take = hsel_i & htrans_i[1] & hready_i;
	assign rd_take = take & ~hwrite_i;

	function automatic logic [31:0] rd_mux(input logic [7:0] a,
		input i2csm_core_type s);
		logic [31:0] r;
		r = 32'h00000000;
		case (a)
			`I2CSM_OFF_STATUS: begin
				r[`I2CSM_ST_START] = s.start_f;
				r[`I2CSM_ST_RW] = s.rw_f;
				r[`I2CSM_ST_RBF] = s.receive_full_flag;
				r[`I2CSM_ST_TBF] = s.transmit_full_flag;
			end
			`I2CSM_OFF_MASK: r[9:0] = s.mask;
			`I2CSM_OFF_RXHOLD: r[7:0] = s.rx_hold;
			`I2CSM_OFF_TXHOLD: r[7:0] = s.tx_hold;
			`I2CSM_OFF_CTRL: begin
				r[9:0] = s.own;
				r[`I2CSM_CTRL_TEN] = s.ten;
			end
			default: r = 32'h00000000;
		endcase
		rd_mux = r;
	endfunction

	always_comb begin
		logic set_tbf;
		logic rd_rx;
		set_tbf = 1'b0;
		rd_rx = 1'b0;
		n = q;
		n.sy_start = {q.sy_start[1:0], lk.start_tgl};
		n.sy_stop = {q.sy_stop[1:0], lk.stop_tgl};
		n.sy_addr = {q.sy_addr[1:0], lk.addr_tgl};
		n.sy_rx = {q.sy_rx[1:0], lk.rx_tgl};
		n.sy_txd = {q.sy_txd[1:0], lk.txd_tgl};

		// Data phase of a write taken in the previous cycle
		if (q.wr_pend) begin
			case (q.wr_addr)
				`I2CSM_OFF_MASK: begin
					n.mask = hwdata_i[9:0];
					n.cfg_tgl = ~q.cfg_tgl;
				end
				`I2CSM_OFF_TXHOLD: begin
					// A write over a pending byte would race the link read
					if (!q.transmit_full_flag) begin
						n.tx_hold = hwdata_i[7:0];
						set_tbf = 1'b1;
					end
				end
				`I2CSM_OFF_CTRL: begin
					n.own = hwdata_i[9:0];
					n.ten = hwdata_i[`I2CSM_CTRL_TEN];
					n.cfg_tgl = ~q.cfg_tgl;
				end
				default: ;
			endcase
		end

		if (ev_start) begin
			n.start_f = 1'b1;
		end else if (ev_stop) begin
			n.start_f = 1'b0;
		end
		if (ev_addr) begin
			n.rw_f = lk.addr_rw;
		end
		if (ev_rx) begin
			n.rx_hold = lk.rx_byte;
		end

		rd_rx = rd_take && haddr_i[7:0] == `I2CSM_OFF_RXHOLD;
		n.receive_full_flag = ev_rx | (q.receive_full_flag & ~rd_rx);
		n.transmit_full_flag = set_tbf | (q.transmit_full_flag & ~ev_txd);

		n.wr_pend = take & hwrite_i;
		n.wr_addr = haddr_i[7:0];
		if (rd_take) begin
			n.hrdata = rd_mux(haddr_i[7:0], n);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{mask: `I2CSM_MASK_RST, own: `I2CSM_OWN_RST, default: '0};
		end else begin
			q <= n;
		end
	end

	// Zero-wait slave; every answer is OKAY
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	assign hrdata_o = q.hrdata;
	assign lk.cfg_tgl = q.cfg_tgl;
	assign lk.mask = q.mask;
	assign lk.own = q.own;
	assign lk.ten = q.ten;
	assign lk.tx_full = q.transmit_full_flag;
	assign lk.tx_byte = q.tx_hold;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_start_set;
		ev_start |=> q.start_f ##1 (q.start_f || ev_stop || $past(ev_stop));
	endproperty
	a_start_set: assert property (p_start_set) else $error("start lost");

	property p_stop_clr;
		(ev_stop && !ev_start) |=> !q.start_f;
	endproperty
	a_stop_clr: assert property (p_stop_clr) else $error("stop ignored");

	property p_dir;
		ev_addr |=> q.rw_f == $past(lk.addr_rw);
	endproperty
	a_dir: assert property (p_dir) else $error("direction stale");

	property p_rx_set;
		ev_rx |=> q.receive_full_flag && q.rx_hold == $past(lk.rx_byte);
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("rx not loaded");

	property p_rx_clr;
		(rd_take && haddr_i[7:0] == `I2CSM_OFF_RXHOLD && !ev_rx) |=>
			!q.receive_full_flag && hrdata_o[7:0] == q.rx_hold;
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("rx read kept full");

	property p_tx_set;
		(q.wr_pend && q.wr_addr == `I2CSM_OFF_TXHOLD && !q.transmit_full_flag) |=>
			q.transmit_full_flag && q.tx_hold == $past(hwdata_i[7:0]);
	endproperty
	a_tx_set: assert property (p_tx_set) else $error("tx write lost");

	property p_tx_clr;
		(ev_txd && !(q.wr_pend && q.wr_addr == `I2CSM_OFF_TXHOLD)) |=> !q.transmit_full_flag;
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx never empties");

	property p_mask_rd;
		(q.wr_pend && q.wr_addr == `I2CSM_OFF_MASK) ##1 !q.wr_pend ##1
		(rd_take && haddr_i[7:0] == `I2CSM_OFF_MASK && !q.wr_pend) |=>
			hrdata_o == {22'h000000, $past(hwdata_i[9:0], 3)};
	endproperty
	a_mask_rd: assert property (p_mask_rd) else $error("mask readback bad");

	// A flag moves only on its own event or access; all else holds it
	property p_st_both;
		(ev_start && ev_stop) |=> q.start_f;
	endproperty
	a_st_both: assert property (p_st_both) else $error("start lost");

	property p_st_hold;
		(!ev_start && !ev_stop) |=> $stable(q.start_f);
	endproperty
	a_st_hold: assert property (p_st_hold) else $error("start moved");

	property p_dir_hold;
		!ev_addr |=> $stable(q.rw_f);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("dir moved");

	property p_rbf_win;
		(ev_rx && rd_take && haddr_i[7:0] == `I2CSM_OFF_RXHOLD) |=> q.receive_full_flag;
	endproperty
	a_rbf_win: assert property (p_rbf_win) else $error("rx flag lost");

	property p_rbf_hold;
		(!ev_rx && !(rd_take && haddr_i[7:0] == `I2CSM_OFF_RXHOLD)) |=>
			$stable(q.receive_full_flag);
	endproperty
	a_rbf_hold: assert property (p_rbf_hold) else $error("rx flag moved");

	property p_rx_keep;
		!ev_rx |=> $stable(q.rx_hold);
	endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("rx data moved");

	property p_rd_hold;
		!rd_take |=> $stable(hrdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

	property p_stat_rd;
		(rd_take && haddr_i[7:0] == `I2CSM_OFF_STATUS) |=>
			hrdata_o == {28'h0000000, q.start_f, q.rw_f, q.receive_full_flag, q.transmit_full_flag};
	endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status word bad");

	property p_tx_keep;
		!(q.wr_pend && q.wr_addr == `I2CSM_OFF_TXHOLD && !q.transmit_full_flag) |=>
			$stable(q.tx_hold);
	endproperty
	a_tx_keep: assert property (p_tx_keep) else $error("tx overwritten");

	property p_tbf_hold;
		(!ev_txd && !(q.wr_pend && q.wr_addr == `I2CSM_OFF_TXHOLD)) |=>
			$stable(q.transmit_full_flag);
	endproperty
	a_tbf_hold: assert property (p_tbf_hold) else $error("tx flag moved");

	// The link copies its config only on this toggle
	property p_cfg_sent;
		(q.wr_pend && (q.wr_addr == `I2CSM_OFF_MASK ||
			q.wr_addr == `I2CSM_OFF_CTRL)) |=> q.cfg_tgl != $past(q.cfg_tgl);
	endproperty
	a_cfg_sent: assert property (p_cfg_sent) else $error("cfg not sent");

	property p_ten_hold;
		!(q.wr_pend && q.wr_addr == `I2CSM_OFF_CTRL) |=> $stable(q.ten);
	endproperty
	a_ten_hold: assert property (p_ten_hold) else $error("mode moved");

	property p_own_hold;
		!(q.wr_pend && q.wr_addr == `I2CSM_OFF_CTRL) |=> $stable(q.own);
	endproperty
	a_own_hold: assert property (p_own_hold) else $error("own moved");

	property p_mask_hi;
		(rd_take && haddr_i[7:0] == `I2CSM_OFF_MASK) |=>
			hrdata_o[31:10] == 22'h000000;
	endproperty
	a_mask_hi: assert property (p_mask_hi) else $error("mask high bits");

	property p_msk_hold;
		!(q.wr_pend && q.wr_addr == `I2CSM_OFF_MASK) |=> $stable(q.mask);
	endproperty
	a_msk_hold: assert property (p_msk_hold) else $error("mask moved");

	c_start: cover property (ev_start ##[1:200] ev_stop);
	c_rx: cover property (ev_rx ##[1:400] rd_take);
	c_txd: cover property (q.transmit_full_flag ##[1:1000] ev_txd);
	c_mask: cover property (q.wr_pend && q.wr_addr == `I2CSM_OFF_MASK);
endmodule

// >>> hw/i2csm_map.svh
// Register offsets, field positions and reset values of the I2C status unit.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef I2CSM_MAP_SVH
`define I2CSM_MAP_SVH

`define I2CSM_OFF_STATUS 8'h00
`define I2CSM_OFF_MASK 8'h04
`define I2CSM_OFF_RXHOLD 8'h08
`define I2CSM_OFF_TXHOLD 8'h0C
`define I2CSM_OFF_CTRL 8'h10

`define I2CSM_ST_START 3
`define I2CSM_ST_RW 2
`define I2CSM_ST_RBF 1
`define I2CSM_ST_TBF 0

`define I2CSM_MASK_W 10
`define I2CSM_MASK_RST 10'h000
`define I2CSM_OWN_RST 10'h000
`define I2CSM_CTRL_TEN 10

`define I2CSM_HDR10 5'h1E
`define I2CSM_IDLE_BYTE 8'hFF

`endif

// >>> hw/i2csm_pkg.sv
// Types and the address compare shared by the register side and the link.
// Assumes the map header is on the include path.
`include "i2csm_map.svh"
package i2csm_pkg;

	typedef enum logic [3:0] {
		LK_IDLE, LK_ADDR, LK_ACK_H, LK_ADDR2, LK_ACK_A,
		LK_RX, LK_ACK_RX, LK_TX, LK_TX_ACK
	} i2csm_lstate_type;

	typedef struct packed {
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic start_f;
		logic rw_f;
		logic receive_full_flag;
		logic transmit_full_flag;
		logic [9:0] mask;
		logic [9:0] own;
		logic ten;
		logic [7:0] rx_hold;
		logic [7:0] tx_hold;
		logic cfg_tgl;
		logic [2:0] sy_start;
		logic [2:0] sy_stop;
		logic [2:0] sy_addr;
		logic [2:0] sy_rx;
		logic [2:0] sy_txd;
	} i2csm_core_type;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] cfg_s;
		logic [1:0] txf_s;
		logic [9:0] mask;
		logic [9:0] own;
		logic ten;
		i2csm_lstate_type state;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic [7:0] txsh;
		logic ten_hit;
		logic oe_n;
		logic start_tgl;
		logic stop_tgl;
		logic addr_tgl;
		logic addr_rw;
		logic rx_tgl;
		logic [7:0] rx_byte;
		logic txd_tgl;
	} i2csm_link_type;

	// Set mask bits force their position to match
	function automatic logic i2csm_match(input logic [9:0] inc,
		input logic [9:0] own, input logic [9:0] msk);
		i2csm_match = &((~(inc ^ own)) | msk);
	endfunction

endpackage

// >>> hw/i2csm_link_if.sv
// Signals crossing between the register side and the link side.
// Toggles mark events; data words stand still around each toggle.
`timescale 1ns/1ps
interface i2csm_link_if;
	logic start_tgl;
	logic stop_tgl;
	logic addr_tgl;
	logic addr_rw;
	logic rx_tgl;
	logic [7:0] rx_byte;
	logic txd_tgl;
	logic cfg_tgl;
	logic [9:0] mask;
	logic [9:0] own;
	logic ten;
	logic tx_full;
	logic [7:0] tx_byte;

	modport core (
		input start_tgl, stop_tgl, addr_tgl, addr_rw, rx_tgl, rx_byte,
		input txd_tgl,
		output cfg_tgl, mask, own, ten, tx_full, tx_byte
	);
	modport link (
		output start_tgl, stop_tgl, addr_tgl, addr_rw, rx_tgl, rx_byte,
		output txd_tgl,
		input cfg_tgl, mask, own, ten, tx_full, tx_byte
	);
endinterface

// >>> hw/i2csm_link.sv
// I2C slave bit engine on the link clock: start/stop detect, address
// match, receive and transmit. Assumes the link clock oversamples SCL.
`timescale 1ns/1ps
module i2csm_link (
	input wire logic link_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	i2csm_link_if.link lk
);
	import i2csm_pkg::*;

	i2csm_link_type q, n;
	logic scl, rise, fall, start, stop, sda;

	assign scl = q.scl_s[1];
	assign sda = q.sda_s[1];
	assign rise = q.scl_s[1] & ~q.scl_s[2];
	assign fall = ~q.scl_s[1] & q.scl_s[2];
	assign start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
	assign stop = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];

	always_comb begin
		n = q;
		n.scl_s = {q.scl_s[1:0], scl_i};
		n.sda_s = {q.sda_s[1:0], sda_i};
		n.cfg_s = {q.cfg_s[1:0], lk.cfg_tgl};
		n.txf_s = {q.txf_s[0], lk.tx_full};
		// Config words were written well before their toggle arrives
		if (q.cfg_s[2] ^ q.cfg_s[1]) begin
			n.mask = lk.mask;
			n.own = lk.own;
			n.ten = lk.ten;
		end
		if (start) begin
			n.start_tgl = ~q.start_tgl;
			n.state = LK_ADDR;
			n.cnt = 4'h0;
			n.oe_n = 1'b1;
		end else if (stop) begin
			n.stop_tgl = ~q.stop_tgl;
			n.state = LK_IDLE;
			n.ten_hit = 1'b0;
			n.oe_n = 1'b1;
		end else if (rise) begin
			unique case (q.state)
				LK_ADDR, LK_ADDR2, LK_RX: begin
					n.sr = {q.sr[6:0], sda};
					n.cnt = q.cnt + 4'h1;
				end
				LK_TX_ACK: n.sr = {q.sr[6:0], sda};
				default: ;
			endcase
		end else if (fall) begin
			unique case (q.state)
				LK_ADDR: if (q.cnt == 4'h8) begin
					n.state = LK_IDLE;
					if (!q.ten) begin
						n.ten_hit = 1'b0;
						if (i2csm_match({3'h0, q.sr[7:1]}, {3'h0, q.own[6:0]},
							{3'h0, q.mask[6:0]})) begin
							n.state = LK_ACK_A;
							n.oe_n = 1'b0;
							n.addr_rw = q.sr[0];
							n.addr_tgl = ~q.addr_tgl;
						end
					end else if (q.sr[7:3] == `I2CSM_HDR10 &&
						i2csm_match({8'h00, q.sr[2:1]}, {8'h00, q.own[9:8]},
						{8'h00, q.mask[9:8]})) begin
						if (!q.sr[0]) begin
							n.state = LK_ACK_H;
							n.oe_n = 1'b0;
						end else if (q.ten_hit) begin
							n.state = LK_ACK_A;
							n.oe_n = 1'b0;
							n.addr_rw = 1'b1;
							n.addr_tgl = ~q.addr_tgl;
						end
					end else begin
						n.ten_hit = 1'b0;
					end
				end
				LK_ACK_H: begin
					n.oe_n = 1'b1;
					n.state = LK_ADDR2;
					n.cnt = 4'h0;
				end
				LK_ADDR2: if (q.cnt == 4'h8) begin
					n.state = LK_IDLE;
					n.ten_hit = 1'b0;
					if (i2csm_match({2'h0, q.sr}, {2'h0, q.own[7:0]},
						{2'h0, q.mask[7:0]})) begin
						n.state = LK_ACK_A;
						n.oe_n = 1'b0;
						n.ten_hit = 1'b1;
						n.addr_rw = 1'b0;
						n.addr_tgl = ~q.addr_tgl;
					end
				end
				LK_ACK_A, LK_TX_ACK: begin
					n.cnt = 4'h0;
					n.oe_n = 1'b1;
					if (q.state == LK_TX_ACK) begin
						n.txd_tgl = ~q.txd_tgl;
					end
					if (q.state == LK_TX_ACK && q.sr[0]) begin
						n.state = LK_IDLE;
					end else if (q.addr_rw) begin
						// Nothing queued: idle pattern; full mirror is stale later
						n.txsh = (q.txf_s[1] && q.state == LK_ACK_A) ?
							lk.tx_byte : `I2CSM_IDLE_BYTE;
						n.oe_n = n.txsh[7];
						n.txsh = {n.txsh[6:0], 1'b1};
						n.cnt = 4'h1;
						n.state = LK_TX;
					end else begin
						n.state = LK_RX;
					end
				end
				LK_RX: if (q.cnt == 4'h8) begin
					n.rx_byte = q.sr;
					n.rx_tgl = ~q.rx_tgl;
					n.oe_n = 1'b0;
					n.state = LK_ACK_RX;
				end
				LK_ACK_RX: begin
					n.oe_n = 1'b1;
					n.cnt = 4'h0;
					n.state = LK_RX;
				end
				LK_TX: if (q.cnt == 4'h8) begin
					n.oe_n = 1'b1;
					n.state = LK_TX_ACK;
				end else begin
					n.oe_n = q.txsh[7];
					n.txsh = {q.txsh[6:0], 1'b1};
					n.cnt = q.cnt + 4'h1;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{scl_s: 3'h7, sda_s: 3'h7, oe_n: 1'b1, mask: `I2CSM_MASK_RST,
				own: `I2CSM_OWN_RST, state: LK_IDLE, sr: 8'h00, default: '0};
		end else begin
			q <= n;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_n_o = q.oe_n;
	assign lk.start_tgl = q.start_tgl;
	assign lk.stop_tgl = q.stop_tgl;
	assign lk.addr_tgl = q.addr_tgl;
	assign lk.addr_rw = q.addr_rw;
	assign lk.rx_tgl = q.rx_tgl;
	assign lk.rx_byte = q.rx_byte;
	assign lk.txd_tgl = q.txd_tgl;

	default clocking cb @(posedge link_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_mask10;
		(q.state == LK_ADDR2 && fall && !start && !stop && q.cnt == 4'h8 &&
		((q.sr ^ q.own[7:0]) & ~q.mask[7:0]) == 8'h00)
		|=> (q.state == LK_ACK_A && !q.oe_n && q.ten_hit) ##1 !q.oe_n;
	endproperty
	a_mask10: assert property (p_mask10) else $error("10-bit masked miss");

	property p_mask7;
		(q.state == LK_ADDR && fall && !start && !stop && q.cnt == 4'h8 &&
		!q.ten && ((q.sr[7:1] ^ q.own[6:0]) & ~q.mask[6:0]) == 7'h00)
		|=> q.state == LK_ACK_A && !q.oe_n && q.addr_rw == $past(q.sr[0]);
	endproperty
	a_mask7: assert property (p_mask7) else $error("7-bit masked miss");

	property p_exact;
		(q.state == LK_ADDR && fall && !start && !stop && q.cnt == 4'h8 &&
		!q.ten && ((q.sr[7:1] ^ q.own[6:0]) & ~q.mask[6:0]) != 7'h00)
		|=> q.state == LK_IDLE && q.oe_n && $stable(q.addr_tgl);
	endproperty
	a_exact: assert property (p_exact) else $error("unmasked bit ignored");

	c_tx_byte: cover property (q.state == LK_TX_ACK && fall && !q.sr[0]);
endmodule

// >>> bench/i2csm_bus_master.sv
// Behavioural I2C bus master that addresses the unit as a slave.
// Assumes SDA has a pull-up and the bench folds all drivers into one wire.
`timescale 1ns/1ps
module i2csm_bus_master (
	output logic scl_o,
	output logic sda_low_o,
	input wire logic sda_i
);
	// Ten link clocks per half bit, so the slave's sync delay fits easily
	localparam int HALF = 300;

	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// SCL stands high between frames; a low SCL here means repeated start
	task automatic start();
		#(HALF/2) sda_low_o = 1'b0;
		#(HALF/2) scl_o = 1'b1;
		#HALF sda_low_o = 1'b1;
		#HALF scl_o = 1'b0;
	endtask

	task automatic send_bit(input logic b);
		#(HALF/2) sda_low_o = ~b;
		#(HALF/2) scl_o = 1'b1;
		#HALF scl_o = 1'b0;
	endtask

	// Released SDA floats to the pull-up, never to a stale value
	task automatic get_bit(output logic b);
		#(HALF/2) sda_low_o = 1'b0;
		#(HALF/2) scl_o = 1'b1;
		#(HALF/2) b = sda_i;
		#(HALF/2) scl_o = 1'b0;
	endtask

	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			send_bit(d[i]);
		end
		get_bit(b);
		ack = ~b;
	endtask

	task automatic read_byte(output logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			get_bit(d[i]);
		end
		send_bit(~ack);
	endtask

	task automatic stop();
		#(HALF/2) sda_low_o = 1'b1;
		#(HALF/2) scl_o = 1'b1;
		#HALF sda_low_o = 1'b0;
		#HALF;
	endtask
endmodule

// >>> bench/i2c_status_and_address_mask_tb.sv
// Self-checking bench: AHB-Lite register traffic plus I2C frames.
// Assumes the unit answers with zero wait states and an open-drain SDA.
`timescale 1ns/1ps
module i2c_status_and_address_mask_tb;
	typedef struct {
		logic wr;
		logic [7:0] off;
		logic [31:0] data;
	} i2csm_row_type;

	logic ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic hready, hresp, scl, m_low, sda_out, sda_oe_n, sda_line, ack;
	logic [31:0] rd;
	logic [7:0] d;
	int mismatches = 0, checks = 0;

	// Writes carry data; reads carry the expected value
	i2csm_row_type rows [12] = '{
		'{1'b0, 8'h04, 32'h0}, '{1'b0, 8'h00, 32'h0},
		'{1'b1, 8'h04, 32'hFFFFFFFF}, '{1'b0, 8'h04, 32'h3FF},
		'{1'b1, 8'h04, 32'h0}, '{1'b0, 8'h14, 32'h0},
		'{1'b1, 8'h14, 32'hFFFF}, '{1'b0, 8'h14, 32'h0},
		'{1'b1, 8'h0C, 32'h3C}, '{1'b0, 8'h00, 32'h1},
		'{1'b1, 8'h0C, 32'h77}, '{1'b0, 8'h0C, 32'h3C}};

	always #10 ref_clk = ~ref_clk;
	initial #7 forever #15 link_clk = ~link_clk;
	assign sda_line = !(m_low || (sda_oe_n === 1'b0 && sda_out === 1'b0));

	i2csm_top i_i2csm_top (.ref_clk_i(ref_clk), .rst_i(rst),
		.link_clk_i(link_clk), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(hresp), .hrdata_o(hrdata), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_out), .sda_oe_n_o(sda_oe_n));
	i2csm_bus_master i_i2csm_bus_master (.scl_o(scl), .sda_low_o(m_low),
		.sda_i(sda_line));

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] off,
		input logic [31:0] wd, output logic [31:0] rdata);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, off};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hready !== 1'b1);
		check("hresp", {31'h0, hresp}, 32'h0);
		rdata = hrdata;
	endtask

	// Flags cross two clock domains, a few cycles each way
	task automatic status(input logic [31:0] exp);
		repeat (20) @(posedge ref_clk);
		ahb(1'b0, 8'h00, 32'h0, rd);
		check("status", rd, exp);
	endtask

	task automatic frame(input logic [7:0] a, input logic [7:0] b,
		input logic two, input logic exp);
		i_i2csm_bus_master.start();
		i_i2csm_bus_master.write_byte(a, ack);
		if (two) begin
			i_i2csm_bus_master.write_byte(b, ack);
		end
		check("ack", {31'h0, ack}, {31'h0, exp});
		i_i2csm_bus_master.stop();
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#500000;
		mismatches++;
		end_of_test();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			ahb(rows[i].wr, rows[i].off, rows[i].data, rd);
			if (!rows[i].wr) check("reg", rd, rows[i].data);
		end
		ahb(1'b1, 8'h10, 32'h2A, rd);
		repeat (20) @(posedge ref_clk);
		// Write frame: address match, then one received byte
		i_i2csm_bus_master.start();
		i_i2csm_bus_master.write_byte(8'h54, ack);
		check("ack", {31'h0, ack}, 32'h1);
		status(32'h9);
		i_i2csm_bus_master.write_byte(8'hA5, ack);
		status(32'hB);
		ahb(1'b0, 8'h08, 32'h0, rd);
		check("rxhold", rd, 32'hA5);
		status(32'h9);
		// Repeated start into a read drains the queued byte
		i_i2csm_bus_master.start();
		i_i2csm_bus_master.write_byte(8'h55, ack);
		status(32'hD);
		i_i2csm_bus_master.read_byte(d, 1'b0);
		check("txbyte", {24'h0, d}, 32'h3C);
		i_i2csm_bus_master.stop();
		status(32'h4);
		frame(8'h56, 8'h0, 1'b0, 1'b0);
		ahb(1'b1, 8'h04, 32'h1, rd);
		repeat (20) @(posedge ref_clk);
		frame(8'h56, 8'h0, 1'b0, 1'b1);
		// Ten-bit mode, mask over address bits 7:4
		ahb(1'b1, 8'h10, 32'h6A5, rd);
		ahb(1'b0, 8'h10, 32'h0, rd);
		check("ctrl", rd, 32'h6A5);
		// Config words cross by toggle; keep writes well apart
		repeat (20) @(posedge ref_clk);
		ahb(1'b1, 8'h04, 32'hF0, rd);
		repeat (20) @(posedge ref_clk);
		frame(8'hF4, 8'h95, 1'b1, 1'b1);
		frame(8'hF4, 8'hA4, 1'b1, 1'b0);
		// Ten-bit read: repeated start with the read header, nothing queued
		i_i2csm_bus_master.start();
		i_i2csm_bus_master.write_byte(8'hF4, ack);
		i_i2csm_bus_master.write_byte(8'h95, ack);
		i_i2csm_bus_master.start();
		i_i2csm_bus_master.write_byte(8'hF5, ack);
		check("ack", {31'h0, ack}, 32'h1);
		i_i2csm_bus_master.read_byte(d, 1'b0);
		check("txbyte", {24'h0, d}, 32'hFF);
		i_i2csm_bus_master.stop();
		status(32'h4);
		// Reset in mid-run returns the mask to zero
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		ahb(1'b0, 8'h04, 32'h0, rd);
		check("mask", rd, 32'h0);
		end_of_test();
	end
endmodule
